// >>> inc/hie_params.svh
`ifndef HIE_PARAMS_SVH
`define HIE_PARAMS_SVH

// register indices inside one port; byte address is four times the index
`define HIE_LINK_EN_OFS   9'h150
`define HIE_SEQ_EN_OFS    9'h151
`define HIE_FRAME_EN_OFS  9'h153
`define HIE_CHAN_EN_OFS   9'h154
`define HIE_CTRL_EN_OFS   9'h155

// port bases as register indices
`define HIE_PORT0_BASE    10'h000
`define HIE_PORT1_BASE    10'h200

// own interrupt registers, as register indices
`define HIE_IRQ_STAT_IDX  10'h3F0
`define HIE_IRQ_MASK_IDX  10'h3F1

// implemented enable bits per register
`define HIE_LINK_EN_MASK  8'h1F
`define HIE_SEQ_EN_MASK   8'h0F
`define HIE_FRAME_EN_MASK 8'h07
`define HIE_CHAN_EN_MASK  8'h1F
`define HIE_CTRL_EN_MASK  8'hF3

// reset values
`define HIE_EN_RESET      8'h00
`define HIE_IRQ_RESET     10'h000

// summary bit positions of the top interrupt status
`define HIE_SUM_LINK      0
`define HIE_SUM_SEQ       1
`define HIE_SUM_FRAME     2
`define HIE_SUM_CHAN      3
`define HIE_SUM_CTRL      4

`endif

// >>> inc/hie_pkg.sv
package hie_pkg;

  typedef logic [7:0] hie_byte_t;
  typedef logic [4:0] hie_sum_t;
  typedef logic [9:0] hie_irq_t;

  typedef enum logic [1:0] {
    HIE_IDLE = 2'b01,
    HIE_RESP = 2'b10
  } hie_bus_state_t;

endpackage : hie_pkg

// >>> hw/hie_port.sv
`timescale 1ns/10ps
`include "hie_params.svh"

module hie_port (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // register access
  input  wire logic             wr_in,
  input  wire logic [8:0]       ofs_in,
  input  wire logic [7:0]       wdata_in,
  output logic      [7:0]       rdata_out,
  // status factors
  input  wire logic [4:0]       link_stat_in,
  input  wire logic [3:0]       seq_stat_in,
  input  wire logic [2:0]       frame_stat_in,
  input  wire logic [4:0]       chan_stat_in,
  input  wire logic [7:0]       ctrl_stat_in,
  // enables and summary
  output logic      [7:0]       link_en_out,
  output logic      [7:0]       seq_en_out,
  output logic      [7:0]       frame_en_out,
  output logic      [7:0]       chan_en_out,
  output hie_pkg::hie_sum_t     summary_out
);
  import hie_pkg::*;

  function automatic logic [2:0] reg_index(input logic [8:0] ofs);
    case (ofs)
      `HIE_LINK_EN_OFS:  reg_index = 3'd0;
      `HIE_SEQ_EN_OFS:   reg_index = 3'd1;
      `HIE_FRAME_EN_OFS: reg_index = 3'd2;
      `HIE_CHAN_EN_OFS:  reg_index = 3'd3;
      `HIE_CTRL_EN_OFS:  reg_index = 3'd4;
      default:           reg_index = 3'd7;
    endcase
  endfunction : reg_index

  function automatic logic [7:0] mask_of(input logic [2:0] idx);
    case (idx)
      3'd0:    mask_of = `HIE_LINK_EN_MASK;
      3'd1:    mask_of = `HIE_SEQ_EN_MASK;
      3'd2:    mask_of = `HIE_FRAME_EN_MASK;
      3'd3:    mask_of = `HIE_CHAN_EN_MASK;
      3'd4:    mask_of = `HIE_CTRL_EN_MASK;
      default: mask_of = 8'h00;
    endcase
  endfunction : mask_of

  hie_byte_t  en_reg [0:4];
  hie_sum_t   summary_reg;
  hie_sum_t   summary_next;
  logic [2:0] idx;
  logic       idx_ok;

  assign idx    = reg_index(ofs_in);
  assign idx_ok = (idx != 3'd7);
  assign rdata_out = idx_ok ? (en_reg[idx] & mask_of(idx)) : 8'h00;

  assign summary_next[`HIE_SUM_LINK]  = |(link_stat_in & en_reg[0][4:0]);
  assign summary_next[`HIE_SUM_SEQ]   = |(seq_stat_in & en_reg[1][3:0]);
  assign summary_next[`HIE_SUM_FRAME] = |(frame_stat_in & en_reg[2][2:0]);
  assign summary_next[`HIE_SUM_CHAN]  = |(chan_stat_in & en_reg[3][4:0]);
  assign summary_next[`HIE_SUM_CTRL]  = |(ctrl_stat_in & en_reg[4]);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 5; i++) begin
        en_reg[i] <= `HIE_EN_RESET;
      end
      summary_reg <= 5'h0;
    end else begin
      if (wr_in && idx_ok) begin
        en_reg[idx] <= wdata_in & mask_of(idx);
      end
      summary_reg <= summary_next;
    end
  end

  assign link_en_out  = en_reg[0];
  assign seq_en_out   = en_reg[1];
  assign frame_en_out = en_reg[2];
  assign chan_en_out  = en_reg[3];
  assign summary_out  = summary_reg;

endmodule : hie_port

// >>> hw/hie_top.sv
// What this block does
// - two identical enable sets, port 0 at base 000h, port 1 at 200h.
// - link summary set only when an enabled link event factor is set.
// - link enables: connect 4, disconnect 3, wakeup 2, chirp good 1, bad 0.
// - sequence enables: disabled 3, resume 2, suspend 1, reset 0 gate summary.
// - frame summary set only when an enabled frame factor is set.
// - frame enables: port error 2, frame number wrap 1, frame start 0.
// - channel summary set only when an enabled channel factor is set.
// - channel enables bits 0 to 4 for channels a to e.
// - control summary set only when an enabled control factor is set.
// - control enables at bits 7,6,5,4,1,0.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "hie_params.svh"

module hie_top (
  // clock and reset
  input  wire logic              CLK_SYS_IN,
  input  wire logic              RESET_IN,
  // wishbone slave
  input  wire logic              WB_CYC_IN,
  input  wire logic              WB_STB_IN,
  input  wire logic              WB_WE_IN,
  input  wire logic [11:0]       WB_ADR_IN,
  input  wire logic [3:0]        WB_SEL_IN,
  input  wire logic [31:0]       WB_DAT_IN,
  output logic      [31:0]       WB_DAT_OUT,
  output logic                   WB_ACK_OUT,
  // port 0 status factors
  input  wire logic [4:0]        P0_LINK_EVENT_STATUS_IN,
  input  wire logic [3:0]        P0_SEQUENCE_DONE_STATUS_IN,
  input  wire logic [2:0]        P0_FRAME_EVENT_STATUS_IN,
  input  wire logic [4:0]        P0_CHANNEL_SUMMARY_STATUS_IN,
  input  wire logic [7:0]        P0_CONTROL_CHANNEL_STATUS_IN,
  // port 1 status factors
  input  wire logic [4:0]        P1_LINK_EVENT_STATUS_IN,
  input  wire logic [3:0]        P1_SEQUENCE_DONE_STATUS_IN,
  input  wire logic [2:0]        P1_FRAME_EVENT_STATUS_IN,
  input  wire logic [4:0]        P1_CHANNEL_SUMMARY_STATUS_IN,
  input  wire logic [7:0]        P1_CONTROL_CHANNEL_STATUS_IN,
  // summaries and interrupt
  output hie_pkg::hie_sum_t      P0_TOP_INTERRUPT_STATUS_OUT,
  output hie_pkg::hie_sum_t      P1_TOP_INTERRUPT_STATUS_OUT,
  output logic                   IRQ_OUT
);
  import hie_pkg::*;

  hie_bus_state_t state_reg;
  hie_bus_state_t state_next;
  logic           ack_reg;
  logic [31:0]    dat_reg;
  hie_irq_t       irq_stat_reg;
  hie_irq_t       irq_stat_next;
  hie_irq_t       irq_mask_reg;
  hie_irq_t       irq_mask_next;
  logic           irq_reg;

  // decode
  logic [9:0]  adr_idx;
  logic [8:0]  ofs;
  logic        req;
  logic        wr_req;
  logic        port1_hit;
  logic        stat_hit;
  logic        mask_hit;
  logic        wr_p0;
  logic        wr_p1;
  logic        wr_lo;
  logic        wr_hi;
  logic [7:0]  p0_rd;
  logic [7:0]  p1_rd;
  logic [31:0] rd_data;
  hie_irq_t    irq_set;
  hie_irq_t    irq_clr;
  hie_irq_t    wr_word;

  // port enables, seen by checks
  logic [7:0]  p0_link_en;
  logic [7:0]  p0_seq_en;
  logic [7:0]  p0_frame_en;
  logic [7:0]  p0_chan_en;
  logic [7:0]  p1_link_en;
  logic [7:0]  p1_seq_en;
  logic [7:0]  p1_frame_en;
  logic [7:0]  p1_chan_en;
  hie_sum_t    p0_sum;
  hie_sum_t    p1_sum;

  assign adr_idx = WB_ADR_IN[11:2];
  assign ofs     = adr_idx[8:0];
  // one answer per request; the response cycle between keeps a held strobe from retriggering
  assign req     = WB_CYC_IN && WB_STB_IN && (state_reg == HIE_IDLE);
  assign wr_req  = req && WB_WE_IN;
  assign port1_hit = ((adr_idx & `HIE_PORT1_BASE) != `HIE_PORT0_BASE);
  assign stat_hit  = (adr_idx == `HIE_IRQ_STAT_IDX);
  assign mask_hit  = (adr_idx == `HIE_IRQ_MASK_IDX);
  assign wr_lo     = wr_req && WB_SEL_IN[0];
  assign wr_hi     = wr_req && WB_SEL_IN[1];
  assign wr_p0     = wr_lo && !port1_hit;
  assign wr_p1     = wr_lo && port1_hit && !stat_hit && !mask_hit;

  assign rd_data = stat_hit  ? {22'h0, irq_stat_reg} :
                   mask_hit  ? {22'h0, irq_mask_reg} :
                   port1_hit ? {24'h0, p1_rd} :
                               {24'h0, p0_rd};

  // a response cycle always returns to idle, so a held strobe is not taken twice
  always_comb begin
    case (state_reg)
      HIE_IDLE: state_next = req ? HIE_RESP : HIE_IDLE;
      HIE_RESP: state_next = HIE_IDLE;
      default:  state_next = HIE_IDLE;
    endcase
  end

  // sticky events; set wins over a clear in the same cycle
  assign wr_word = {wr_hi ? WB_DAT_IN[9:8] : 2'b00, wr_lo ? WB_DAT_IN[7:0] : 8'h00};
  assign irq_set = {p1_sum, p0_sum};
  assign irq_clr = stat_hit ? wr_word : 10'h000;
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
  assign irq_mask_next = {
    (mask_hit && wr_hi) ? WB_DAT_IN[9:8] : irq_mask_reg[9:8],
    (mask_hit && wr_lo) ? WB_DAT_IN[7:0] : irq_mask_reg[7:0]
  };

  hie_port u_port0 (
    .clk_in        (CLK_SYS_IN),
    .reset_in      (RESET_IN),
    .wr_in         (wr_p0),
    .ofs_in        (ofs),
    .wdata_in      (WB_DAT_IN[7:0]),
    .rdata_out     (p0_rd),
    .link_stat_in  (P0_LINK_EVENT_STATUS_IN),
    .seq_stat_in   (P0_SEQUENCE_DONE_STATUS_IN),
    .frame_stat_in (P0_FRAME_EVENT_STATUS_IN),
    .chan_stat_in  (P0_CHANNEL_SUMMARY_STATUS_IN),
    .ctrl_stat_in  (P0_CONTROL_CHANNEL_STATUS_IN),
    .link_en_out   (p0_link_en),
    .seq_en_out    (p0_seq_en),
    .frame_en_out  (p0_frame_en),
    .chan_en_out   (p0_chan_en),
    .summary_out   (p0_sum)
  );

  hie_port u_port1 (
    .clk_in        (CLK_SYS_IN),
    .reset_in      (RESET_IN),
    .wr_in         (wr_p1),
    .ofs_in        (ofs),
    .wdata_in      (WB_DAT_IN[7:0]),
    .rdata_out     (p1_rd),
    .link_stat_in  (P1_LINK_EVENT_STATUS_IN),
    .seq_stat_in   (P1_SEQUENCE_DONE_STATUS_IN),
    .frame_stat_in (P1_FRAME_EVENT_STATUS_IN),
    .chan_stat_in  (P1_CHANNEL_SUMMARY_STATUS_IN),
    .ctrl_stat_in  (P1_CONTROL_CHANNEL_STATUS_IN),
    .link_en_out   (p1_link_en),
    .seq_en_out    (p1_seq_en),
    .frame_en_out  (p1_frame_en),
    .chan_en_out   (p1_chan_en),
    .summary_out   (p1_sum)
  );

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      state_reg <= HIE_IDLE;
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      ack_reg   <= req;
      dat_reg   <= req ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      irq_stat_reg <= `HIE_IRQ_RESET;
      irq_mask_reg <= `HIE_IRQ_RESET;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      // one cycle behind the status, so the pin stays glitch free
      irq_reg      <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  assign WB_ACK_OUT = ack_reg;
  assign WB_DAT_OUT = dat_reg;
  assign IRQ_OUT    = irq_reg;
  assign P0_TOP_INTERRUPT_STATUS_OUT = p0_sum;
  assign P1_TOP_INTERRUPT_STATUS_OUT = p1_sum;

  // checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);

  a_port1_write: assert property (
    (wr_p1 && ofs == `HIE_LINK_EN_OFS) |=>
      (p1_link_en == ($past(WB_DAT_IN[7:0]) & `HIE_LINK_EN_MASK)) && $stable(p0_link_en))
    else $error("port 1 write landed wrongly");

  a_port0_isolated: assert property (
    (wr_p0 && ofs == `HIE_CHAN_EN_OFS) |=> $stable(p1_chan_en))
    else $error("port 0 write disturbed port 1");

  a_link_summary: assert property (
    ##1 (p0_sum[`HIE_SUM_LINK] ==
      |($past(P0_LINK_EVENT_STATUS_IN) & $past(p0_link_en[4:0]))))
    else $error("link summary mismatch");

  a_link_bits: assert property (
    (wr_p0 && ofs == `HIE_LINK_EN_OFS) |=>
      p0_link_en == ($past(WB_DAT_IN[7:0]) & 8'h1F))
    else $error("link enable field wrong");

  a_p1_link_gate: assert property (
    ##1 (p1_sum[`HIE_SUM_LINK] ==
      |($past(P1_LINK_EVENT_STATUS_IN) & $past(p1_link_en[4:0]))))
    else $error("port 1 link summary mismatch");

  a_p1_seq_gate: assert property (
    ##1 (p1_sum[`HIE_SUM_SEQ] ==
      |($past(P1_SEQUENCE_DONE_STATUS_IN) & $past(p1_seq_en[3:0]))))
    else $error("port 1 sequence summary mismatch");

  a_p1_frame_gate: assert property (
    ##1 (p1_sum[`HIE_SUM_FRAME] ==
      |($past(P1_FRAME_EVENT_STATUS_IN) & $past(p1_frame_en[2:0]))))
    else $error("port 1 frame summary mismatch");

  a_p1_chan_gate: assert property (
    ##1 (p1_sum[`HIE_SUM_CHAN] ==
      |($past(P1_CHANNEL_SUMMARY_STATUS_IN) & $past(p1_chan_en[4:0]))))
    else $error("port 1 channel summary mismatch");

  a_p1_ctrl_quiet: assert property (
    (P1_CONTROL_CHANNEL_STATUS_IN == 8'h00) |=> !p1_sum[`HIE_SUM_CTRL])
    else $error("port 1 control summary without factor");

  a_seq_summary: assert property (
    (p1_seq_en[3:0] == 4'h0) ##1 (p1_seq_en[3:0] == 4'h0) |-> !p1_sum[`HIE_SUM_SEQ])
    else $error("sequence summary without enable");

  a_seq_gate: assert property (
    ##1 (p0_sum[`HIE_SUM_SEQ] ==
      |($past(P0_SEQUENCE_DONE_STATUS_IN) & $past(p0_seq_en[3:0]))))
    else $error("sequence summary mismatch");

  a_frame_summary: assert property (
    ##1 (p0_sum[`HIE_SUM_FRAME] ==
      |($past(P0_FRAME_EVENT_STATUS_IN) & $past(p0_frame_en[2:0]))))
    else $error("frame summary mismatch");

  a_frame_bits: assert property (
    (wr_p0 && ofs == `HIE_FRAME_EN_OFS) |=> p0_frame_en[7:3] == 5'h00)
    else $error("frame enable upper bits set");

  a_chan_summary: assert property (
    ##1 (p0_sum[`HIE_SUM_CHAN] ==
      |($past(P0_CHANNEL_SUMMARY_STATUS_IN) & $past(p0_chan_en[4:0]))))
    else $error("channel summary mismatch");

  a_chan_bits: assert property (
    (wr_p0 && ofs == `HIE_CHAN_EN_OFS && WB_DAT_IN[0]) |=> ##1
      (p0_sum[`HIE_SUM_CHAN] == ($past(P0_CHANNEL_SUMMARY_STATUS_IN[0]) ||
       |($past(P0_CHANNEL_SUMMARY_STATUS_IN[4:1]) & $past(p0_chan_en[4:1])))))
    else $error("channel a enable not effective");

  a_ctrl_summary: assert property (
    (P0_CONTROL_CHANNEL_STATUS_IN == 8'h00) |=> !p0_sum[`HIE_SUM_CTRL])
    else $error("control summary without factor");

  a_ctrl_read: assert property (
    (req && !WB_WE_IN && !port1_hit && ofs == `HIE_CTRL_EN_OFS) |=>
      WB_ACK_OUT && (WB_DAT_OUT[3:2] == 2'b00) && (WB_DAT_OUT[31:8] == 24'h00_0000))
    else $error("control enable read shows holes");

  a_reset_clear: assert property (
    disable iff (1'b0) RESET_IN |=>
      (p0_link_en == 8'h00) && (p1_seq_en == 8'h00) && (p0_sum == 5'h00))
    else $error("enables not cleared by reset");

  a_unmapped_zero: assert property (
    (req && !WB_WE_IN && ofs == 9'h152 && !stat_hit && !mask_hit) |=>
      WB_DAT_OUT == 32'h0000_0000)
    else $error("unassigned register reads nonzero");

  a_ack_single: assert property (
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");

  a_sticky_hold: assert property (
    (irq_stat_reg[0] && !(wr_lo && stat_hit && WB_DAT_IN[0])) |=> irq_stat_reg[0])
    else $error("sticky status lost");

  a_irq_level: assert property (
    ##1 (IRQ_OUT == |($past(irq_stat_reg) & $past(irq_mask_reg))))
    else $error("interrupt level mismatch");

  c_port1_write: cover property (wr_p1 && ofs == `HIE_CTRL_EN_OFS);
  c_link_summary: cover property (p0_sum[`HIE_SUM_LINK] ##1 IRQ_OUT);
  c_clear_race: cover property (stat_hit && wr_lo && |(irq_clr & irq_set));
  c_port1_summary: cover property (p1_sum[`HIE_SUM_FRAME]);
  c_port1_control: cover property (p1_sum[`HIE_SUM_CTRL]);

endmodule : hie_top

// >>> testbench/hie_top_bench.sv
`timescale 1ns/10ps
`include "hie_params.svh"

module hie_top_bench;
  import hie_pkg::*;

  typedef struct {
    logic [9:0] idx;
    logic [7:0] msk;
    int         lo;
    int         w;
  } hie_row_t;

  logic        clk_sys;
  logic        reset;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic        irq;
  hie_sum_t    sum [2];
  logic [24:0] st [2];
  int          n_errors = 0;
  int          comparisons = 0;
  // last row is an unmapped hole between the enable registers
  hie_row_t    rows [6] = '{
    '{`HIE_LINK_EN_OFS, `HIE_LINK_EN_MASK, 0, 5},
    '{`HIE_SEQ_EN_OFS, `HIE_SEQ_EN_MASK, 5, 4},
    '{`HIE_FRAME_EN_OFS, `HIE_FRAME_EN_MASK, 9, 3},
    '{`HIE_CHAN_EN_OFS, `HIE_CHAN_EN_MASK, 12, 5},
    '{`HIE_CTRL_EN_OFS, `HIE_CTRL_EN_MASK, 17, 8},
    '{10'h152, 8'h00, 0, 0}};

  hie_top DUT (
    .CLK_SYS_IN                   (clk_sys),
    .RESET_IN                     (reset),
    .WB_CYC_IN                    (cyc),
    .WB_STB_IN                    (stb),
    .WB_WE_IN                     (we),
    .WB_ADR_IN                    (adr),
    .WB_SEL_IN                    (sel),
    .WB_DAT_IN                    (wdat),
    .WB_DAT_OUT                   (rdat),
    .WB_ACK_OUT                   (ack),
    .P0_LINK_EVENT_STATUS_IN      (st[0][4:0]),
    .P0_SEQUENCE_DONE_STATUS_IN   (st[0][8:5]),
    .P0_FRAME_EVENT_STATUS_IN     (st[0][11:9]),
    .P0_CHANNEL_SUMMARY_STATUS_IN (st[0][16:12]),
    .P0_CONTROL_CHANNEL_STATUS_IN (st[0][24:17]),
    .P1_LINK_EVENT_STATUS_IN      (st[1][4:0]),
    .P1_SEQUENCE_DONE_STATUS_IN   (st[1][8:5]),
    .P1_FRAME_EVENT_STATUS_IN     (st[1][11:9]),
    .P1_CHANNEL_SUMMARY_STATUS_IN (st[1][16:12]),
    .P1_CONTROL_CHANNEL_STATUS_IN (st[1][24:17]),
    .P0_TOP_INTERRUPT_STATUS_OUT  (sum[0]),
    .P1_TOP_INTERRUPT_STATUS_OUT  (sum[1]),
    .IRQ_OUT                      (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // one classic cycle; request held until ack is sampled, then idle a cycle
  task automatic wb(input logic w, input logic [9:0] idx, input logic [3:0] s,
                    input logic [31:0] wd, output logic [31:0] rv);
    int n;
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    sel  <= s;
    wdat <= wd;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t no bus answer", $time);
    end
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask : wb

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle

  initial begin
    #300000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    logic [24:0] gm;
    logic [9:0]  a;
    logic        e;
    {cyc, stb, we, adr, sel, wdat} = '0;
    st[0] = '0;
    st[1] = '0;
    reset = 1'b1;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    // reset values of both ports, and the hole reads zero
    for (int p = 0; p < 2; p++)
      for (int r = 0; r < 6; r++) begin
        a = (p ? `HIE_PORT1_BASE : `HIE_PORT0_BASE) + rows[r].idx;
        wb(1'b0, a, 4'hF, 32'h0, rd);
        check(rd, 32'h0);
      end
    // table: write all ones, read back only the implemented bits
    for (int p = 0; p < 2; p++)
      for (int r = 0; r < 6; r++) begin
        a = (p ? `HIE_PORT1_BASE : `HIE_PORT0_BASE) + rows[r].idx;
        wb(1'b1, a, 4'hF, 32'hFFFF_FFFF, rd);
        wb(1'b0, a, 4'hF, 32'h0, rd);
        check(rd, {24'h0, rows[r].msk});
        if (p == 0) begin
          wb(1'b0, a + `HIE_PORT1_BASE, 4'hF, 32'h0, rd);
          check(rd, 32'h0);
        end
      end
    // byte lane 0 off leaves the enable byte untouched
    wb(1'b1, `HIE_LINK_EN_OFS, 4'hE, 32'h0, rd);
    wb(1'b0, `HIE_LINK_EN_OFS, 4'hF, 32'h0, rd);
    check(rd, 32'h0000_001F);
    // walk one enable bit against all-ones and all-but-that-bit status
    for (int p = 0; p < 2; p++)
      for (int r = 0; r < 5; r++) begin
        a = (p ? `HIE_PORT1_BASE : `HIE_PORT0_BASE) + rows[r].idx;
        gm = ((25'd1 << rows[r].w) - 25'd1) << rows[r].lo;
        for (int k = 0; k < 8; k++) begin
          e = rows[r].msk[k];
          wb(1'b1, a, 4'h1, 32'(1 << k), rd);
          st[p] <= gm;
          settle(3);
          check(32'(sum[p]), 32'(e) << r);
          @(posedge clk_sys);
          st[p] <= gm & ~(25'd1 << (rows[r].lo + k));
          settle(3);
          check(32'(sum[p]), 32'h0);
        end
        @(posedge clk_sys);
        st[p] <= '0;
      end
    // sticky status gathered every group; mask still zero keeps the line low
    settle(3);
    check(32'(irq), 32'h0);
    wb(1'b0, `HIE_IRQ_STAT_IDX, 4'h3, 32'h0, rd);
    check(rd, 32'h0000_03FF);
    wb(1'b1, `HIE_IRQ_MASK_IDX, 4'h3, 32'h0000_0001, rd);
    settle(3);
    check(32'(irq), 32'h1);
    wb(1'b1, `HIE_IRQ_STAT_IDX, 4'h3, 32'h0000_03FF, rd);
    settle(3);
    check(32'(irq), 32'h0);
    // port 1 link event reaches status bit 5, masked until enabled
    wb(1'b1, `HIE_PORT1_BASE + `HIE_LINK_EN_OFS, 4'h1, 32'h1, rd);
    st[1] <= 25'h1;
    settle(4);
    check(32'(irq), 32'h0);
    wb(1'b0, `HIE_IRQ_STAT_IDX, 4'h3, 32'h0, rd);
    check(rd, 32'h0000_0020);
    wb(1'b1, `HIE_IRQ_MASK_IDX, 4'h3, 32'h0000_0020, rd);
    settle(3);
    check(32'(irq), 32'h1);
    // clearing while the summary is still high lets the bit set again
    wb(1'b1, `HIE_IRQ_STAT_IDX, 4'h3, 32'h0000_0020, rd);
    settle(3);
    wb(1'b0, `HIE_IRQ_STAT_IDX, 4'h3, 32'h0, rd);
    check(rd, 32'h0000_0020);
    // second reset in mid-run with the event still present
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    settle(3);
    check(32'(irq), 32'h0);
    check(32'(sum[1]), 32'h0);
    wb(1'b0, `HIE_PORT1_BASE + `HIE_LINK_EN_OFS, 4'hF, 32'h0, rd);
    check(rd, 32'h0);
    stop_test();
  end

endmodule : hie_top_bench
